// ---- rtl/clk_gate_pkg.sv ----
package clk_gate_pkg;

   typedef enum logic [1:0] {
      MODE_MAIN    = 2'h0,
      MODE_MAIN_CR = 2'h1,
      MODE_SUB     = 2'h2,
      MODE_SUB_CR  = 2'h3
   } clk_mode_e;

   typedef enum logic [2:0] {
      ST_RUN   = 3'h0,
      ST_SLEEP = 3'h1,
      ST_TBT   = 3'h2,
      ST_WATCH = 3'h3,
      ST_STOP  = 3'h4
   } run_state_e;

   localparam clk_mode_e MODE_RST = MODE_MAIN_CR;
   localparam run_state_e STATE_RST = ST_RUN;
   localparam logic MAIN_OSC_EN_RST = 1'h0;
   localparam logic MAIN_RC_OSC_EN_RST = 1'h1;
   localparam logic SUB_OSC_EN_RST = 1'h0;
   localparam logic SUB_RC_OSC_EN_RST = 1'h0;
   localparam int SYNC_STAGES = 2;

   function automatic logic is_main_side(input clk_mode_e m);
      return (m == MODE_MAIN) || (m == MODE_MAIN_CR);
   endfunction

   function automatic logic is_standby(input run_state_e s);
      return s != ST_RUN;
   endfunction

endpackage

// ---- rtl/clock_standby_gating_matrix.sv ----
module clock_standby_gating_matrix
   import clk_gate_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic mode_req_valid,
   input wire clk_gate_pkg::clk_mode_e mode_req,
   input wire logic standby_req_valid,
   input wire clk_gate_pkg::run_state_e standby_req,
   input wire logic wake,
   input wire logic main_osc_enable,
   input wire logic main_rc_osc_enable,
   input wire logic sub_osc_enable,
   input wire logic sub_rc_osc_enable,
   input wire logic hw_wdt_start,
   input wire logic hw_wdt_standby_disable,
   input wire logic io_hiz_select,
   input wire logic main_osc_tick,
   input wire logic sub_osc_tick,
   output clk_gate_pkg::clk_mode_e mode_q,
   output clk_gate_pkg::run_state_e state_q,
   output logic main_osc_run,
   output logic main_rc_osc_run,
   output logic sub_osc_run,
   output logic sub_rc_osc_run,
   output logic main_clk_q,
   output logic sub_clk_q,
   output logic cpu_clk_en,
   output logic mem_clk_en,
   output logic io_clk_en,
   output logic io_hiz,
   output logic tbt_clk_en,
   output logic watch_pre_clk_en,
   output logic hw_wdt_run,
   output logic sw_wdt_clk_en,
   output logic ext_int_clk_en,
   output logic lvd_run,
   output logic periph_clk_en
);
   import clk_gate_pkg::*;

   logic main_en_q, main_en_d;
   logic main_rc_en_q, main_rc_en_d;
   logic sub_en_q, sub_en_d;
   logic sub_rc_en_q, sub_rc_en_d;
   logic wdt_started_q, wdt_started_d;
   logic [SYNC_STAGES-1:0] main_sync_q, main_sync_d;
   logic [SYNC_STAGES-1:0] sub_sync_q, sub_sync_d;
   logic main_tick_last_q, main_tick_last_d;
   logic sub_tick_last_q, sub_tick_last_d;
   logic main_clk_d, sub_clk_d;
   logic main_side, run_st, stop_st;

   mode_state_reg u_mode_state (
      .clk(clk),
      .srst(srst),
      .mode_req_valid(mode_req_valid),
      .mode_req(mode_req),
      .standby_req_valid(standby_req_valid),
      .standby_req(standby_req),
      .wake(wake),
      .mode_q(mode_q),
      .state_q(state_q)
   );

   // Enable bits and watchdog start latch
   always_comb begin
      main_en_d = main_osc_enable;
      main_rc_en_d = main_rc_osc_enable;
      sub_en_d = sub_osc_enable;
      sub_rc_en_d = sub_rc_osc_enable;
      wdt_started_d = wdt_started_q | hw_wdt_start;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         main_en_q <= MAIN_OSC_EN_RST;
         main_rc_en_q <= MAIN_RC_OSC_EN_RST;
         sub_en_q <= SUB_OSC_EN_RST;
         sub_rc_en_q <= SUB_RC_OSC_EN_RST;
         wdt_started_q <= 1'b0;
      end else begin
         main_en_q <= main_en_d;
         main_rc_en_q <= main_rc_en_d;
         sub_en_q <= sub_en_d;
         sub_rc_en_q <= sub_rc_en_d;
         wdt_started_q <= wdt_started_d;
      end
   end

   // Divide-by-two of synchronised oscillator ticks
   always_comb begin
      main_sync_d = {main_sync_q[0], main_osc_tick};
      sub_sync_d = {sub_sync_q[0], sub_osc_tick};
      main_tick_last_d = main_sync_q[1];
      sub_tick_last_d = sub_sync_q[1];
      main_clk_d = main_clk_q;
      sub_clk_d = sub_clk_q;
      if (main_osc_run && main_sync_q[1] && !main_tick_last_q) begin
         main_clk_d = !main_clk_q;
      end
      if (sub_osc_run && sub_sync_q[1] && !sub_tick_last_q) begin
         sub_clk_d = !sub_clk_q;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         main_sync_q <= '0;
         sub_sync_q <= '0;
         main_tick_last_q <= 1'b0;
         sub_tick_last_q <= 1'b0;
         main_clk_q <= 1'b0;
         sub_clk_q <= 1'b0;
      end else begin
         main_sync_q <= main_sync_d;
         sub_sync_q <= sub_sync_d;
         main_tick_last_q <= main_tick_last_d;
         sub_tick_last_q <= sub_tick_last_d;
         main_clk_q <= main_clk_d;
         sub_clk_q <= sub_clk_d;
      end
   end

   // Gating matrix
   always_comb begin
      main_side = is_main_side(mode_q);
      run_st = (state_q == ST_RUN);
      stop_st = (state_q == ST_STOP);
      main_osc_run = 1'b0;
      main_rc_osc_run = 1'b0;
      if (state_q == ST_RUN || state_q == ST_SLEEP || state_q == ST_TBT) begin
         main_osc_run = (mode_q == MODE_MAIN) | ((mode_q == MODE_MAIN_CR) & main_en_q);
         main_rc_osc_run = (mode_q == MODE_MAIN_CR) | ((mode_q == MODE_MAIN) & main_rc_en_q);
      end
      if (stop_st) begin
         sub_osc_run = main_side & sub_en_q;
         sub_rc_osc_run = main_side & sub_rc_en_q;
         watch_pre_clk_en = main_side & (sub_en_q | sub_rc_en_q);
      end else begin
         sub_osc_run = (mode_q == MODE_SUB) | sub_en_q;
         sub_rc_osc_run = (mode_q == MODE_SUB_CR) | sub_rc_en_q;
         watch_pre_clk_en = !main_side | sub_en_q | sub_rc_en_q;
      end
      cpu_clk_en = run_st;
      mem_clk_en = run_st;
      io_clk_en = run_st;
      io_hiz = io_hiz_select & (state_q == ST_TBT || stop_st);
      sw_wdt_clk_en = run_st;
      periph_clk_en = run_st | (state_q == ST_SLEEP);
      tbt_clk_en = main_side & (state_q == ST_RUN || state_q == ST_SLEEP || state_q == ST_TBT);
      hw_wdt_run = wdt_started_q & (run_st | !hw_wdt_standby_disable);
      ext_int_clk_en = 1'b1;
      lvd_run = 1'b1;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence enter_standby_s;
      state_q == ST_RUN && standby_req_valid;
   endsequence

   sequence wake_s;
      is_standby(state_q) && wake;
   endsequence

   AST_WATCH_PRE_MAIN_STOP: assert property (
      stop_st && mode_q == MODE_MAIN && sub_en_q && sub_rc_en_q |-> watch_pre_clk_en)
      else $error("Watch prescaler not clocked in main mode stop");
   AST_HW_WDT_KEEPS: assert property (
      wdt_started_q && !hw_wdt_standby_disable |-> hw_wdt_run)
      else $error("Started watchdog stopped");
   AST_MAIN_OSC_CR: assert property (
      mode_q == MODE_MAIN_CR && !stop_st && state_q != ST_WATCH |-> main_osc_run == main_en_q)
      else $error("Main oscillator not following its enable");
   AST_MAIN_RC_MAIN: assert property (
      mode_q == MODE_MAIN && !stop_st |-> main_rc_osc_run == main_rc_en_q)
      else $error("Main CR oscillator not following its enable");
   AST_SUB_OSC_EN: assert property (
      mode_q != MODE_SUB && (!stop_st || main_side) |-> sub_osc_run == sub_en_q)
      else $error("Subclock oscillator not following its enable");
   AST_SUB_RC_EN: assert property (
      mode_q != MODE_SUB_CR && (!stop_st || main_side) |-> sub_rc_osc_run == sub_rc_en_q)
      else $error("Sub-CR oscillator not following its enable");
   AST_HW_WDT_STBY_OFF: assert property (
      is_standby(state_q) && hw_wdt_standby_disable |-> !hw_wdt_run)
      else $error("Watchdog runs in standby while disabled");
   AST_SLEEP_GATES: assert property (
      state_q == ST_SLEEP |-> !cpu_clk_en && !sw_wdt_clk_en && !mem_clk_en
         && tbt_clk_en == main_side)
      else $error("Sleep gating wrong");
   AST_TBT_GATES: assert property (
      state_q == ST_TBT |-> !cpu_clk_en && !periph_clk_en && tbt_clk_en
         && io_hiz == io_hiz_select)
      else $error("Time-base timer state gating wrong");
   AST_WATCH_GATES: assert property (
      state_q == ST_WATCH |-> !main_osc_run && !main_rc_osc_run && !tbt_clk_en
         && watch_pre_clk_en && !periph_clk_en)
      else $error("Watch state gating wrong");
   AST_STOP_GATES: assert property (
      stop_st |-> !main_osc_run && !main_rc_osc_run && !tbt_clk_en
         && (main_side || (!sub_osc_run && !sub_rc_osc_run && !watch_pre_clk_en)))
      else $error("Stop state gating wrong");
   AST_ALWAYS_ALIVE: assert property (
      ext_int_clk_en && lvd_run && (stop_st || (mode_q == MODE_MAIN ? main_osc_run :
         mode_q == MODE_MAIN_CR ? main_rc_osc_run :
         mode_q == MODE_SUB ? sub_osc_run : sub_rc_osc_run)))
      else $error("Always-on logic or active oscillator stopped");
   AST_DIV2: assert property (
      main_osc_run && main_sync_q[1] && !main_tick_last_q |=> main_clk_q != $past(main_clk_q))
      else $error("Main divide-by-two missed a tick");
   AST_STATE_LEGAL: assert property (
      (state_q == ST_TBT |-> main_side) and (state_q == ST_WATCH |-> !main_side))
      else $error("Standby state illegal for clock mode");
   AST_ENTER_STBY: assert property (
      enter_standby_s and (standby_req == ST_SLEEP) |=> state_q == ST_SLEEP ##0 $stable(mode_q))
      else $error("Sleep request not taken");
   AST_WAKE_RUN: assert property (
      wake_s |=> state_q == ST_RUN && cpu_clk_en)
      else $error("Wake did not restore run gating");

endmodule

// ---- rtl/mode_state_reg.sv ----
module mode_state_reg
   import clk_gate_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic mode_req_valid,
   input wire clk_gate_pkg::clk_mode_e mode_req,
   input wire logic standby_req_valid,
   input wire clk_gate_pkg::run_state_e standby_req,
   input wire logic wake,
   output clk_gate_pkg::clk_mode_e mode_q,
   output clk_gate_pkg::run_state_e state_q
);
   clk_mode_e mode_d;
   run_state_e state_d;
   logic legal;

   always_comb begin
      mode_d = mode_q;
      state_d = state_q;
      legal = 1'b0;
      unique case (standby_req)
         ST_SLEEP, ST_STOP: legal = 1'b1;
         ST_TBT: legal = is_main_side(mode_q);
         ST_WATCH: legal = !is_main_side(mode_q);
         default: legal = 1'b0;
      endcase
      unique case (state_q)
         ST_RUN: begin
            if (standby_req_valid && legal) begin
               state_d = standby_req;
            end else if (mode_req_valid) begin
               mode_d = mode_req;
            end
         end
         ST_SLEEP, ST_TBT, ST_WATCH, ST_STOP: begin
            if (wake) begin
               state_d = ST_RUN;
            end
         end
         default: state_d = ST_RUN;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         mode_q <= MODE_RST;
         state_q <= STATE_RST;
      end else begin
         mode_q <= mode_d;
         state_q <= state_d;
      end
   end

endmodule

// ---- verif/testbench.sv ----
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import clk_gate_pkg::*;

   logic clk, srst, mode_req_valid, standby_req_valid, wake;
   clk_mode_e mode_req;
   run_state_e standby_req;
   logic main_osc_enable, main_rc_osc_enable, sub_osc_enable, sub_rc_osc_enable;
   logic hw_wdt_start, hw_wdt_standby_disable, io_hiz_select, main_osc_tick, sub_osc_tick;
   clk_mode_e mode_q;
   run_state_e state_q;
   logic main_osc_run, main_rc_osc_run, sub_osc_run, sub_rc_osc_run, main_clk_q, sub_clk_q;
   logic cpu_clk_en, mem_clk_en, io_clk_en, io_hiz, tbt_clk_en, watch_pre_clk_en, hw_wdt_run;
   logic sw_wdt_clk_en, ext_int_clk_en, lvd_run, periph_clk_en;
   logic [12:0] gates;
   int n_fail, compares;
   run_state_e sts [3] = '{ST_SLEEP, ST_WATCH, ST_STOP};

   // Gate vector: cpu mem io sw_wdt periph tbt watch_pre osc[4] ext_int lvd
   assign gates = {cpu_clk_en, mem_clk_en, io_clk_en, sw_wdt_clk_en, periph_clk_en,
      tbt_clk_en, watch_pre_clk_en, main_osc_run, main_rc_osc_run, sub_osc_run,
      sub_rc_osc_run, ext_int_clk_en, lvd_run};

   clock_standby_gating_matrix clock_standby_gating_matrix_inst (
      .clk(clk), .srst(srst), .mode_req_valid(mode_req_valid), .mode_req(mode_req),
      .standby_req_valid(standby_req_valid), .standby_req(standby_req), .wake(wake),
      .main_osc_enable(main_osc_enable), .main_rc_osc_enable(main_rc_osc_enable),
      .sub_osc_enable(sub_osc_enable), .sub_rc_osc_enable(sub_rc_osc_enable),
      .hw_wdt_start(hw_wdt_start), .hw_wdt_standby_disable(hw_wdt_standby_disable),
      .io_hiz_select(io_hiz_select), .main_osc_tick(main_osc_tick),
      .sub_osc_tick(sub_osc_tick), .mode_q(mode_q), .state_q(state_q),
      .main_osc_run(main_osc_run), .main_rc_osc_run(main_rc_osc_run),
      .sub_osc_run(sub_osc_run), .sub_rc_osc_run(sub_rc_osc_run),
      .main_clk_q(main_clk_q), .sub_clk_q(sub_clk_q), .cpu_clk_en(cpu_clk_en),
      .mem_clk_en(mem_clk_en), .io_clk_en(io_clk_en), .io_hiz(io_hiz),
      .tbt_clk_en(tbt_clk_en), .watch_pre_clk_en(watch_pre_clk_en), .hw_wdt_run(hw_wdt_run),
      .sw_wdt_clk_en(sw_wdt_clk_en), .ext_int_clk_en(ext_int_clk_en), .lvd_run(lvd_run),
      .periph_clk_en(periph_clk_en));

   always #5 clk = ~clk;

   task chk(input string nm, input logic [12:0] seen, input logic [12:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task wrap_up;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task mode_to(input clk_mode_e m);
      @(posedge clk);
      mode_req <= m;
      mode_req_valid <= 1'b1;
      @(posedge clk);
      mode_req_valid <= 1'b0;
      #1;
   endtask

   task standby_to(input run_state_e s);
      @(posedge clk);
      standby_req <= s;
      standby_req_valid <= 1'b1;
      @(posedge clk);
      standby_req_valid <= 1'b0;
      #1;
   endtask

   task wake_up;
      @(posedge clk);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      #1;
   endtask

   // Order: main, main CR, sub, sub CR
   task set_en(input logic [3:0] e);
      @(posedge clk);
      {main_osc_enable, main_rc_osc_enable, sub_osc_enable, sub_rc_osc_enable} <= e;
      @(posedge clk);
      #1;
   endtask

   task pulse_tick(input bit sub);
      @(posedge clk);
      if (sub)
         sub_osc_tick <= 1'b1;
      else
         main_osc_tick <= 1'b1;
      repeat (4) @(posedge clk);
      sub_osc_tick <= 1'b0;
      main_osc_tick <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
   endtask

   task sc_reset;
      chk("mode_q", mode_q, MODE_MAIN_CR);
      chk("state_q", state_q, ST_RUN);
      chk("gates", gates, 13'h1f93);
      chk("hw_wdt_run", hw_wdt_run, 1'h0);
   endtask

   task sc_enables;
      set_en(4'hf);
      chk("gates", gates, 13'h1fff);
      set_en(4'h7);
      chk("main_osc_run", main_osc_run, 1'h0);
      set_en(4'hd);
      chk("sub_osc_run", sub_osc_run, 1'h0);
      chk("sub_rc_osc_run", sub_rc_osc_run, 1'h1);
      set_en(4'hf);
      mode_to(MODE_MAIN);
      set_en(4'hb);
      chk("main_rc_osc_run", main_rc_osc_run, 1'h0);
      chk("main_osc_run", main_osc_run, 1'h1);
      set_en(4'hf);
      chk("main_rc_osc_run", main_rc_osc_run, 1'h1);
   endtask

   task sc_sleep;
      standby_to(ST_SLEEP);
      chk("gates", gates, 13'h01ff);
      mode_to(MODE_SUB);
      chk("mode_q", mode_q, MODE_MAIN);
      wake_up;
      chk("state_q", state_q, ST_RUN);
      mode_to(MODE_SUB);
      standby_to(ST_SLEEP);
      chk("gates", gates, 13'h014f);
      wake_up;
   endtask

   task sc_tbt_watch;
      standby_to(ST_TBT);
      chk("state_q", state_q, ST_RUN);
      mode_to(MODE_MAIN);
      @(posedge clk);
      io_hiz_select <= 1'b1;
      standby_to(ST_TBT);
      chk("gates", gates, 13'h00ff);
      chk("io_hiz", io_hiz, 1'h1);
      wake_up;
      standby_to(ST_WATCH);
      chk("state_q", state_q, ST_RUN);
      mode_to(MODE_SUB_CR);
      standby_to(ST_WATCH);
      chk("gates", gates, 13'h004f);
      chk("io_hiz", io_hiz, 1'h0);
      wake_up;
   endtask

   task sc_stop;
      mode_to(MODE_MAIN);
      standby_to(ST_STOP);
      chk("gates", gates, 13'h004f);
      chk("io_hiz", io_hiz, 1'h1);
      set_en(4'hd);
      chk("sub_osc_run", sub_osc_run, 1'h0);
      set_en(4'hf);
      wake_up;
      mode_to(MODE_SUB_CR);
      standby_to(ST_STOP);
      chk("gates", gates, 13'h0003);
      wake_up;
      chk("sub_rc_osc_run", sub_rc_osc_run, 1'h1);
   endtask

   task sc_wdt;
      @(posedge clk);
      hw_wdt_start <= 1'b1;
      @(posedge clk);
      hw_wdt_start <= 1'b0;
      @(posedge clk);
      #1;
      chk("hw_wdt_run", hw_wdt_run, 1'h1);
      foreach (sts[i]) begin
         standby_to(sts[i]);
         chk("hw_wdt_run", hw_wdt_run, 1'h1);
         @(posedge clk);
         hw_wdt_standby_disable <= 1'b1;
         #1;
         chk("hw_wdt_run", hw_wdt_run, 1'h0);
         wake_up;
         chk("hw_wdt_run", hw_wdt_run, 1'h1);
         @(posedge clk);
         hw_wdt_standby_disable <= 1'b0;
      end
   endtask

   // Reset in mid-run, from a standby state
   task sc_rerun;
      standby_to(ST_SLEEP);
      @(posedge clk);
      srst <= 1'b1;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      #1;
      sc_reset;
   endtask

   task sc_div;
      mode_to(MODE_MAIN);
      for (int s = 0; s < 2; s++) begin
         pulse_tick(s[0]);
         chk("div_clk", s ? sub_clk_q : main_clk_q, 1'h1);
         pulse_tick(s[0]);
         chk("div_clk", s ? sub_clk_q : main_clk_q, 1'h0);
      end
      mode_to(MODE_MAIN_CR);
      set_en(4'h7);
      pulse_tick(1'b0);
      chk("main_clk_q", main_clk_q, 1'h0);
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      wrap_up;
   end

   initial begin
      clk = 1'b0;
      srst = 1'b1;
      {mode_req_valid, standby_req_valid, wake, hw_wdt_start} = 4'h0;
      mode_req = MODE_MAIN;
      standby_req = ST_RUN;
      {main_osc_enable, main_rc_osc_enable, sub_osc_enable, sub_rc_osc_enable} = 4'h4;
      {hw_wdt_standby_disable, io_hiz_select, main_osc_tick, sub_osc_tick} = 4'h0;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      #1;
      sc_reset;
      sc_enables;
      sc_sleep;
      sc_tbt_watch;
      sc_stop;
      sc_wdt;
      sc_rerun;
      sc_div;
      wrap_up;
   end
endmodule
